/* core/mlf_detect.sv */
// package of lock-configuration constants and the three lock detectors
`timescale 1ns/10ps
`default_nettype none
package mlf_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] MLF_CFG_ADDR = 8'h92;
	localparam logic [31:0] MLF_CFG_RESET = 32'h0000_0000;
	localparam int MLF_PARITY_BIT = 31;
	localparam int MLF_OVS_EN_BIT = 30;
	localparam int MLF_BEMF_EN_BIT = 29;
	localparam int MLF_ABS_EN_BIT = 28;
	localparam int MLF_OVS_THR_LSB = 25;
	localparam int MLF_BEMF_THR_LSB = 22;
	localparam int MLF_ABS_THR_LSB = 19;
	localparam int MLF_THR_W = 3;
	// upper fields only; lower bits are owned elsewhere
	localparam logic [31:0] MLF_CFG_MASK = 32'hFFF8_0000;
	// ****************************************
	// threshold scaling
	// ****************************************
	localparam int MLF_OVS_BASE_PCT = 130;
	localparam int MLF_BEMF_BASE_PCT = 10;
	localparam int MLF_STEP_PCT = 10;
	localparam int MLF_PCT_FULL = 100;
	// ****************************************
	// lock response selection codes
	// ****************************************
	localparam logic [3:0] MLF_RESP_RETRY_LO = 4'h4;
	localparam logic [3:0] MLF_RESP_REPORT = 4'h8;
	localparam logic [3:0] MLF_RESP_DISABLED_LO = 4'h9;
	typedef enum logic [1:0] {
		MLF_GATE_TRISTATE,
		MLF_GATE_RECIRC,
		MLF_GATE_HS_BRAKE,
		MLF_GATE_LS_BRAKE
	} mlf_gate_t;
	typedef enum {
		MLF_IDLE,
		MLF_LATCHED,
		MLF_RETRY,
		MLF_REPORT
	} mlf_state_t;

	// current threshold in milliamps for a code
	function automatic logic [15:0] mlf_abs_ma(input logic [2:0] code);
		case (code)
			3'h0: mlf_abs_ma = 16'h0032;
			3'h1: mlf_abs_ma = 16'h004B;
			3'h2: mlf_abs_ma = 16'h0064;
			3'h3: mlf_abs_ma = 16'h007D;
			3'h4: mlf_abs_ma = 16'h00FA;
			3'h5: mlf_abs_ma = 16'h01F4;
			3'h6: mlf_abs_ma = 16'h02EE;
			default: mlf_abs_ma = 16'h03E8;
		endcase
	endfunction : mlf_abs_ma

	// percentage for a 3-bit step code over a base
	function automatic logic [31:0] mlf_pct(input int base, input logic [2:0] code);
		mlf_pct = 32'(base) + 32'(MLF_STEP_PCT) * 32'(code);
	endfunction : mlf_pct
endpackage : mlf_pkg

module mlf_lock_detect #(
	parameter int W = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_sample_valid,
	input wire logic [W-1:0] i_speed,
	input wire logic [W-1:0] i_max_speed,
	input wire logic [W-1:0] i_backemf,
	input wire logic [W-1:0] i_expected_backemf,
	input wire logic [15:0] i_phase_current_ma,
	input wire logic i_overspeed_lock_enable,
	input wire logic i_low_backemf_lock_enable,
	input wire logic i_absent_motor_lock_enable,
	input wire logic [2:0] i_overspeed_lock_threshold,
	input wire logic [2:0] i_backemf_lock_threshold,
	input wire logic [2:0] i_absent_motor_current_threshold,
	output logic [2:0] o_trip
);
	import mlf_pkg::*;
	logic ovs_hit;
	logic bemf_hit;
	logic abs_hit;

	// percent comparisons kept in 32 bits so no product wraps
	assign ovs_hit = 32'(i_speed) * 32'(MLF_PCT_FULL) >
		32'(i_max_speed) * mlf_pct(MLF_OVS_BASE_PCT, i_overspeed_lock_threshold);
	assign bemf_hit = 32'(i_backemf) * 32'(MLF_PCT_FULL) <
		32'(i_expected_backemf) * mlf_pct(MLF_BEMF_BASE_PCT, i_backemf_lock_threshold);
	assign abs_hit = i_phase_current_ma < mlf_abs_ma(i_absent_motor_current_threshold);

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_trip <= 3'h0;
		end else begin
			o_trip[0] <= i_sample_valid && i_overspeed_lock_enable && ovs_hit;
			o_trip[1] <= i_sample_valid && i_low_backemf_lock_enable && bemf_hit;
			o_trip[2] <= i_sample_valid && i_absent_motor_lock_enable && abs_hit;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	a_ovs_gate_off: assert property (!i_overspeed_lock_enable |=> !o_trip[0])
		else $error("overspeed trip while disabled");
	a_bemf_gate_off: assert property (!i_low_backemf_lock_enable |=> !o_trip[1])
		else $error("backemf trip while disabled");
	a_abs_gate_off: assert property (!i_absent_motor_lock_enable |=> !o_trip[2])
		else $error("absent motor trip while disabled");
	a_ovs_trip_point: assert property (i_sample_valid && i_overspeed_lock_enable &&
		(i_speed * 100 > i_max_speed * (130 + 10 * i_overspeed_lock_threshold)) |=> o_trip[0])
		else $error("overspeed not tripped");
	a_bemf_trip_point: assert property (i_sample_valid && i_low_backemf_lock_enable &&
		(i_backemf * 100 >= i_expected_backemf * (10 + 10 * i_backemf_lock_threshold)) |=> !o_trip[1])
		else $error("backemf tripped above threshold");
	a_abs_trip_point: assert property (i_sample_valid && i_absent_motor_lock_enable &&
		i_absent_motor_current_threshold == 3'h7 && i_phase_current_ma < 16'h03E8 |=> o_trip[2])
		else $error("absent motor not tripped at top code");
endmodule : mlf_lock_detect
`default_nettype wire

/* core/mlf_lock_config.sv */
// lock fault configuration word, detector instance and lock response
`timescale 1ns/10ps
`default_nettype none
module mlf_lock_config #(
	parameter int W = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_cfg_addr,
	input wire logic i_cfg_wr,
	input wire logic [31:0] i_cfg_wr_data,
	input wire logic i_cfg_rd,
	output logic [31:0] o_cfg_rd_data,
	input wire logic i_sample_valid,
	input wire logic [W-1:0] i_speed,
	input wire logic [W-1:0] i_max_speed,
	input wire logic [W-1:0] i_backemf,
	input wire logic [W-1:0] i_expected_backemf,
	input wire logic [15:0] i_phase_current_ma,
	input wire logic [3:0] i_lock_response_select,
	input wire logic i_retry_expired,
	input wire logic i_retry_exhausted,
	input wire logic i_fault_clear,
	output logic [2:0] o_lock_trip,
	output logic o_lock_fault,
	output logic o_gate_override,
	output var mlf_pkg::mlf_gate_t o_gate_mode,
	output logic o_fault_indicator_pin_n
);
	import mlf_pkg::*;
	logic [31:0] cfg;
	logic [2:0] trip;
	logic trip_any;
	logic cfg_hit;
	mlf_state_t state;
	mlf_state_t next_state;

	// ****************************************
	// configuration word
	// ****************************************
	assign cfg_hit = i_cfg_addr == MLF_CFG_ADDR;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cfg <= MLF_CFG_RESET;
		end else if (i_cfg_wr && cfg_hit) begin
			// parity kept as written, never checked
			cfg <= i_cfg_wr_data & MLF_CFG_MASK;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_cfg_rd_data <= 32'h0000_0000;
		end else if (i_cfg_rd) begin
			o_cfg_rd_data <= cfg_hit ? cfg : 32'h0000_0000;
		end
	end

	// ****************************************
	// detectors
	// ****************************************
	mlf_lock_detect #(.W(W)) u_detect (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_sample_valid(i_sample_valid),
		.i_speed(i_speed),
		.i_max_speed(i_max_speed),
		.i_backemf(i_backemf),
		.i_expected_backemf(i_expected_backemf),
		.i_phase_current_ma(i_phase_current_ma),
		.i_overspeed_lock_enable(cfg[MLF_OVS_EN_BIT]),
		.i_low_backemf_lock_enable(cfg[MLF_BEMF_EN_BIT]),
		.i_absent_motor_lock_enable(cfg[MLF_ABS_EN_BIT]),
		.i_overspeed_lock_threshold(cfg[MLF_OVS_THR_LSB +: MLF_THR_W]),
		.i_backemf_lock_threshold(cfg[MLF_BEMF_THR_LSB +: MLF_THR_W]),
		.i_absent_motor_current_threshold(cfg[MLF_ABS_THR_LSB +: MLF_THR_W]),
		.o_trip(trip)
	);
	assign trip_any = |trip;
	assign o_lock_trip = trip;

	// ****************************************
	// lock response
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			MLF_IDLE: begin
				if (trip_any && i_lock_response_select < MLF_RESP_RETRY_LO) begin
					next_state = MLF_LATCHED;
				end else if (trip_any && i_lock_response_select < MLF_RESP_REPORT) begin
					next_state = MLF_RETRY;
				end else if (trip_any && i_lock_response_select == MLF_RESP_REPORT) begin
					next_state = MLF_REPORT;
				end
			end
			MLF_LATCHED: begin
				// a new trip in the clear cycle keeps the fault
				if (i_fault_clear && !trip_any) begin
					next_state = MLF_IDLE;
				end
			end
			MLF_RETRY: begin
				if (i_retry_exhausted) begin
					next_state = MLF_LATCHED;
				end else if ((i_retry_expired || i_fault_clear) && !trip_any) begin
					next_state = MLF_IDLE;
				end
			end
			MLF_REPORT: begin
				if (i_fault_clear && !trip_any) begin
					next_state = MLF_IDLE;
				end
			end
			default: next_state = MLF_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state <= MLF_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// gate stance is caught with the trip; later select changes wait for the next trip while idle
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_gate_mode <= MLF_GATE_TRISTATE;
		end else if (state == MLF_IDLE && trip_any) begin
			o_gate_mode <= mlf_gate_t'(i_lock_response_select[1:0]);
		end
	end

	assign o_lock_fault = state != MLF_IDLE;
	assign o_gate_override = state == MLF_LATCHED || state == MLF_RETRY;
	assign o_fault_indicator_pin_n = state == MLF_IDLE;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence s_latch_trip;
		state == MLF_IDLE && trip_any && i_lock_response_select < MLF_RESP_RETRY_LO;
	endsequence
	sequence s_hold_no_clear;
		!i_fault_clear [*3];
	endsequence
	a_latch_holds_fault: assert property (s_latch_trip ##1 s_hold_no_clear |->
		o_lock_fault && o_gate_override && !o_fault_indicator_pin_n)
		else $error("latched lock fault did not hold");
	a_disabled_no_fault: assert property (state == MLF_IDLE && i_lock_response_select >= MLF_RESP_DISABLED_LO
		|=> !o_lock_fault)
		else $error("fault raised with detection disabled");
	a_report_no_action: assert property (state == MLF_IDLE && trip_any &&
		i_lock_response_select == MLF_RESP_REPORT |=> o_lock_fault && !o_gate_override)
		else $error("report only took gate action");
	a_parity_stored: assert property (i_cfg_wr && i_cfg_addr == MLF_CFG_ADDR |=>
		cfg[MLF_PARITY_BIT] == $past(i_cfg_wr_data[MLF_PARITY_BIT]))
		else $error("parity bit not stored");

	// ****************************************
	// response assertions
	// ****************************************
	// watched from the outputs where possible, so a decode slip shows up too
	sequence s_retry_trip;
		state == MLF_IDLE && trip_any && i_lock_response_select >= MLF_RESP_RETRY_LO &&
			i_lock_response_select < MLF_RESP_REPORT;
	endsequence
	a_retry_gates_off: assert property (s_retry_trip |=>
		o_lock_fault && o_gate_override && !o_fault_indicator_pin_n)
		else $error("retry fault did not take the gates");
	a_idle_needs_trip: assert property (state == MLF_IDLE && !trip_any |=> !o_lock_fault)
		else $error("fault raised without a trip");
	a_trip_beats_clear: assert property (o_lock_fault && trip_any |=> o_lock_fault)
		else $error("clear won against a fresh trip");
	a_latch_ignores_retry: assert property (state == MLF_LATCHED && !i_fault_clear |=> o_lock_fault)
		else $error("latched fault left without a clear");
	a_retry_expiry_clears: assert property (state == MLF_RETRY && i_retry_expired &&
		!i_retry_exhausted && !trip_any |=> !o_lock_fault)
		else $error("retry expiry did not clear");
	a_exhaust_latches: assert property (state == MLF_RETRY && i_retry_exhausted |=>
		state == MLF_LATCHED)
		else $error("exhausted retries did not latch");
	a_report_pin_only: assert property (state == MLF_REPORT |->
		!o_gate_override && !o_fault_indicator_pin_n)
		else $error("report only state drove the gates");
	a_gate_mode_caught: assert property (state == MLF_IDLE && trip_any |=>
		o_gate_mode == $past(i_lock_response_select[1:0]))
		else $error("gate stance not caught with the trip");
	a_gate_mode_holds: assert property (state != MLF_IDLE |=> $stable(o_gate_mode))
		else $error("gate stance moved during a fault");

	// ****************************************
	// register assertions
	// ****************************************
	// lower bits belong to other fields, so they must read back as zero here
	a_low_bits_clear: assert property ((cfg & ~MLF_CFG_MASK) == 32'h0000_0000)
		else $error("bits outside the lock fields were stored");
	a_unmapped_wr_kept: assert property (i_cfg_wr && !cfg_hit |=> $stable(cfg))
		else $error("unmapped write changed the word");
	a_read_returns_word: assert property (i_cfg_rd && cfg_hit |=>
		o_cfg_rd_data == $past(cfg))
		else $error("read data is not the stored word");
	a_read_unmapped_zero: assert property (i_cfg_rd && !cfg_hit |=>
		o_cfg_rd_data == 32'h0000_0000)
		else $error("unmapped read returned data");
	a_read_data_holds: assert property (!i_cfg_rd |=> $stable(o_cfg_rd_data))
		else $error("read data moved without a read");
endmodule : mlf_lock_config
`default_nettype wire

/* bench/tb_mlf.sv */
// self-checking bench for the lock fault configuration block
`timescale 1ns/10ps
`default_nettype none
module tb;
	import mlf_pkg::*;
	logic i_ref_clk = 0, i_rst = 1, wr = 0, rd = 0, sv = 0, rexp = 0, rexh = 0, clr = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [15:0] spd = 16'h0, mx = 16'h0064, be = 16'h0064, ebe = 16'h0064, cur = 16'h07D0;
	logic [3:0] sel = 4'h9;
	logic [2:0] trip;
	logic fault, ovr, pin_n;
	mlf_gate_t gmode;
	int fails = 0, tests_run = 0;
	int ma[8] = '{50, 75, 100, 125, 250, 500, 750, 1000};
	mlf_lock_config #(.W(16)) u_mlf_lock_config (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg_addr(addr),
		.i_cfg_wr(wr), .i_cfg_wr_data(wdata), .i_cfg_rd(rd), .o_cfg_rd_data(rdata), .i_sample_valid(sv),
		.i_speed(spd), .i_max_speed(mx), .i_backemf(be), .i_expected_backemf(ebe), .i_phase_current_ma(cur),
		.i_lock_response_select(sel), .i_retry_expired(rexp), .i_retry_exhausted(rexh), .i_fault_clear(clr),
		.o_lock_trip(trip), .o_lock_fault(fault), .o_gate_override(ovr), .o_gate_mode(gmode),
		.o_fault_indicator_pin_n(pin_n));
	// ****************************************
	// shared tasks
	// ****************************************
	initial begin
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	// inputs move 5 ns after each edge so the design samples settled values
	task automatic tick;
		@(posedge i_ref_clk);
		#5;
	endtask : tick
	task automatic wr_cfg(input logic [7:0] a, input logic [31:0] v);
		addr = a;
		wdata = v;
		wr = 1;
		tick;
		wr = 0;
		// one idle edge so a following strobe never rises in the same step
		tick;
	endtask : wr_cfg
	task automatic rd_cfg(input logic [7:0] a, output logic [31:0] v);
		addr = a;
		rd = 1;
		tick;
		rd = 0;
		v = rdata;
		tick;
	endtask : rd_cfg
	task automatic sample(input int s, input int b, input int c, input logic [2:0] exp);
		spd = 16'(s);
		be = 16'(b);
		cur = 16'(c);
		sv = 1;
		tick;
		sv = 0;
		chk("lock_trip", trip, exp);
		tick;
	endtask : sample
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reg;
		rd_cfg(8'h92, d);
		chk("reset_word", d, 32'h0);
		chk("pin_n_reset", pin_n, 1'b1);
		chk("fault_reset", fault, 1'b0);
		wr_cfg(8'h92, 32'hFFFF_FFFF);
		rd_cfg(8'h92, d);
		chk("word_all", d, 32'hFFF8_0000);
		wr_cfg(8'h93, 32'h0);
		rd_cfg(8'h92, d);
		chk("unmapped_wr", d, 32'hFFF8_0000);
		rd_cfg(8'h93, d);
		chk("unmapped_rd", d, 32'h0);
		wr_cfg(8'h92, 32'h8000_0000);
		rd_cfg(8'h92, d);
		chk("parity_only", d, 32'h8000_0000);
	endtask : t_reg
	// each code checked exactly at its threshold and one step past it
	task automatic t_thr;
		sel = 4'h9;
		for (int c = 0; c < 8; c++) begin
			wr_cfg(8'h92, 32'h4000_0000 | (32'(c) << 25));
			sample(130 + 10 * c, 100, 2000, 3'h0);
			sample(131 + 10 * c, 100, 2000, 3'h1);
			wr_cfg(8'h92, 32'h2000_0000 | (32'(c) << 22));
			sample(0, 10 + 10 * c, 2000, 3'h0);
			sample(0, 9 + 10 * c, 2000, 3'h2);
			wr_cfg(8'h92, 32'h1000_0000 | (32'(c) << 19));
			sample(0, 100, ma[c], 3'h0);
			sample(0, 100, ma[c] - 1, 3'h4);
		end
		wr_cfg(8'h92, 32'h0);
		sample(300, 0, 0, 3'h0);
	endtask : t_thr
	task automatic t_resp;
		wr_cfg(8'h92, 32'h4000_0000);
		for (int s = 0; s < 10; s++) begin
			sel = 4'(s);
			sample(200, 100, 2000, 3'h1);
			chk("fault", fault, s < 9);
			chk("pin_n", pin_n, !(s < 9));
			chk("override", ovr, s < 8);
			if (s < 8) chk("gate_mode", 32'(gmode), s % 4);
			// no event for a few edges: every response must hold its state
			repeat (3) tick;
			chk("fault_held", fault, s < 9);
			if (s < 4) begin
				rexp = 1;
				tick;
				rexp = 0;
				chk("latch_vs_expiry", fault, 1'b1);
			end
			if (s >= 4 && s < 8) begin
				rexp = 1;
			end else begin
				clr = 1;
			end
			tick;
			rexp = 0;
			clr = 0;
			chk("fault_cleared", fault, 1'b0);
		end
		// exhausted retries latch, so a later expiry must not clear
		sel = 4'h4;
		sample(200, 100, 2000, 3'h1);
		rexh = 1;
		tick;
		rexh = 0;
		rexp = 1;
		tick;
		rexp = 0;
		tick;
		chk("fault_latched", fault, 1'b1);
		chk("override_latched", ovr, 1'b1);
		clr = 1;
		tick;
		clr = 0;
		chk("fault_sw_clear", fault, 1'b0);
	endtask : t_resp
	// reset in mid-fault must drop the fault and the stored word
	task automatic t_rst;
		wr_cfg(8'h92, 32'h4000_0000);
		sel = 4'h3;
		sample(200, 100, 2000, 3'h1);
		chk("fault_pre_rst", fault, 1'b1);
		i_rst = 1;
		tick;
		i_rst = 0;
		chk("fault_rst", fault, 1'b0);
		chk("pin_n_rst", pin_n, 1'b1);
		chk("override_rst", ovr, 1'b0);
		chk("gate_mode_rst", 32'(gmode), 32'h0);
		rd_cfg(8'h92, d);
		chk("word_rst", d, 32'h0);
		sample(200, 100, 2000, 3'h0);
	endtask : t_rst
	initial begin
		#100000;
		fails++;
		end_sim;
	end
	initial begin
		repeat (3) @(posedge i_ref_clk);
		#5;
		i_rst = 0;
		t_reg;
		t_thr;
		t_resp;
		t_rst;
		end_sim;
	end
endmodule : tb
`default_nettype wire
